// ===== common/wdt_defines.vh
// constants shared by the supervisor watchdog design
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_CLK_PERIOD_NS      8
`define WDT_TICK_NS            1000
`define WDT_TICK_CYCLES        (`WDT_TICK_NS / `WDT_CLK_PERIOD_NS)
`define WDT_TIMEOUT_US         1600000
`define WDT_TIMEOUT_TICKS      (`WDT_TIMEOUT_US * 1000 / `WDT_TICK_NS)
`define WDT_HOLD_US            140000
`define WDT_HOLD_TICKS         (`WDT_HOLD_US * 1000 / `WDT_TICK_NS)
`define WDT_STROBE_MIN_NS      50
`define WDT_SYNC_STAGES        2

`define WDT_ST_RUN             2'h0
`define WDT_ST_ASSERT          2'h1
`define WDT_ST_HOLD            2'h2

`endif

// ===== hdl/pin_sync.v
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH    = 1,
   parameter RST_VAL  = 0
) (
   input  wire             sys_clk_in,
   input  wire             rst_b_in,
   input  wire             ce_in,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   // -----------------------------------------------------------
   // synchroniser chain, first stage read only by the second
   // -----------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage1_reg <= RST_VAL[WIDTH-1:0];
         stage2_reg <= RST_VAL[WIDTH-1:0];
      end else if (ce_in) begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;

endmodule // pin_sync

// ===== hdl/supervisor_watchdog_timer.v
// watchdog timer and reset sequencer of a supply supervisor
//
// Overview of operation
// - any strobe edge clears the watchdog counter
// - strobe pulses of 50 ns are caught
// - full timeout without clear asserts reset
// - undervoltage or manual reset clears counter
// - counter held at zero during reset
// - floating strobe input disables the watchdog
// - reset held for hold period after timeout
`timescale 1ns/100ps
`include "wdt_defines.vh"
module supervisor_watchdog_timer #(
   parameter TICK_CYCLES = `WDT_TICK_CYCLES,
   parameter TIMEOUT_TICKS = `WDT_TIMEOUT_TICKS,
   parameter HOLD_TICKS = `WDT_HOLD_TICKS,
   parameter CNT_W = 24
) (
   input  wire sys_clk_in,
   input  wire rst_b_in,
   input  wire ce_in,
   input  wire watchdog_strobe_in,
   input  wire strobe_float_in,
   input  wire supply_low_in,
   input  wire manual_reset_n_in,
   output wire reset_n_out,
   output wire reset_out,
   output wire watchdog_expired_out
);

   // -----------------------------------------------------------
   // constants
   // -----------------------------------------------------------
   // state codes of the reset sequencer
   localparam [1:0] ST_RUN    = `WDT_ST_RUN;
   localparam [1:0] ST_ASSERT = `WDT_ST_ASSERT;
   localparam [1:0] ST_HOLD   = `WDT_ST_HOLD;
   // terminal counts, cut to the counter width on purpose
   localparam [CNT_W-1:0] TICK_LAST = TICK_CYCLES[CNT_W-1:0] - 1'b1;
   localparam [CNT_W-1:0] WD_LAST   = TIMEOUT_TICKS[CNT_W-1:0] - 1'b1;
   localparam [CNT_W-1:0] HOLD_LAST = HOLD_TICKS[CNT_W-1:0] - 1'b1;

   // -----------------------------------------------------------
   // signal declarations
   // -----------------------------------------------------------
   wire [3:0]       pins_sync;
   wire             strobe_s;
   wire             float_s;
   wire             low_s;
   wire             mr_n_s;
   wire             cause;
   wire             strobe_edge;
   wire             tick;
   reg              strobe_last_reg;
   reg [CNT_W-1:0]  tick_cnt_reg;
   reg [CNT_W-1:0]  wd_cnt_reg;
   reg [CNT_W-1:0]  wd_cnt_next;
   reg [CNT_W-1:0]  hold_cnt_reg;
   reg [CNT_W-1:0]  hold_cnt_next;
   reg [1:0]        state_reg;
   reg [1:0]        state_next;
   reg              wd_fire;
   reg              reset_reg;
   reg              expired_reg;

   // -----------------------------------------------------------
   // design notes
   // -----------------------------------------------------------
   // the tick prescaler runs free, so the first tick of a hold
   // period may come early and the hold may fall short by one tick
   // the floating-strobe flag comes from an analog window detector
   // and is treated like any other asynchronous pin
   // priority inside the counter: cause, strobe edge, float, count
   // a low clock enable freezes every flip-flop, synchronisers too,
   // so strobe edges that come and go while frozen are not seen
   // the strobe synchroniser and edge history both reset to the
   // idle low level of the pin, so no false edge follows reset
   // counters must be wide enough for the largest terminal count

   // -----------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------
   // true when a counter has reached its terminal count
   function at_last;
      input [CNT_W-1:0] value;
      input [CNT_W-1:0] last;
      at_last = (value == last);
   endfunction

   // one step up, kept inside the counter width
   function [CNT_W-1:0] bump;
      input [CNT_W-1:0] value;
      bump = value + 1'b1;
   endfunction

   // -----------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------
   // sampling at 8 ns catches a 50 ns strobe level several times
   pin_sync #(
      .WIDTH   (4),
      .RST_VAL (4'h8)                                   // strobe idle low, manual reset released
   ) pin_sync_inst (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .async_in   ({manual_reset_n_in, supply_low_in, strobe_float_in, watchdog_strobe_in}),
      .sync_out   (pins_sync)
   );

   assign strobe_s = pins_sync[0];
   assign float_s  = pins_sync[1];
   assign low_s    = pins_sync[2];
   assign mr_n_s   = pins_sync[3];
   assign cause    = low_s | ~mr_n_s;

   // -----------------------------------------------------------
   // strobe edge detect and time base
   // -----------------------------------------------------------
   // both polarities of transition count
   assign strobe_edge = strobe_s ^ strobe_last_reg;
   assign tick        = at_last(tick_cnt_reg, TICK_LAST);

   // edge history register and tick prescaler
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         strobe_last_reg <= 1'b0;
         tick_cnt_reg    <= {CNT_W{1'b0}};
      end else if (ce_in) begin
         strobe_last_reg <= strobe_s;
         tick_cnt_reg    <= tick ? {CNT_W{1'b0}} : bump(tick_cnt_reg);
      end
   end

   // -----------------------------------------------------------
   // watchdog counter
   // -----------------------------------------------------------
   // cleared by edges, by any reset, and while the pin floats
   always @* begin
      wd_fire     = 1'b0;
      wd_cnt_next = wd_cnt_reg;
      if (reset_reg || cause) begin
         wd_cnt_next = {CNT_W{1'b0}};
      end else if (strobe_edge) begin
         wd_cnt_next = {CNT_W{1'b0}};
      end else if (float_s) begin
         wd_cnt_next = {CNT_W{1'b0}};
      end else if (tick) begin
         if (at_last(wd_cnt_reg, WD_LAST)) begin
            wd_fire     = 1'b1;
            wd_cnt_next = {CNT_W{1'b0}};
         end else begin
            wd_cnt_next = bump(wd_cnt_reg);
         end
      end
   end

   // -----------------------------------------------------------
   // reset sequencer
   // -----------------------------------------------------------
   // assert while a cause stands, then hold for the hold period
   always @* begin
      state_next    = state_reg;
      hold_cnt_next = hold_cnt_reg;
      case (state_reg)
         ST_RUN: begin
            if (cause) begin
               state_next = ST_ASSERT;
            end else if (wd_fire) begin
               state_next    = ST_HOLD;
               hold_cnt_next = {CNT_W{1'b0}};
            end
         end
         ST_ASSERT: begin
            hold_cnt_next = {CNT_W{1'b0}};
            if (!cause) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (cause) begin
               state_next = ST_ASSERT;
            end else if (tick) begin
               if (at_last(hold_cnt_reg, HOLD_LAST)) begin
                  state_next = ST_RUN;
               end else begin
                  hold_cnt_next = bump(hold_cnt_reg);
               end
            end
         end
         default: begin
            state_next = ST_ASSERT;
         end
      endcase
   end

   // state, counters and registered outputs
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg    <= ST_ASSERT;
         wd_cnt_reg   <= {CNT_W{1'b0}};
         hold_cnt_reg <= {CNT_W{1'b0}};
         reset_reg    <= 1'b1;
         expired_reg  <= 1'b0;
      end else if (ce_in) begin
         state_reg    <= state_next;
         wd_cnt_reg   <= wd_cnt_next;
         hold_cnt_reg <= hold_cnt_next;
         reset_reg    <= (state_next != ST_RUN);
         expired_reg  <= wd_fire;
      end
   end

   assign reset_n_out          = ~reset_reg;
   assign reset_out            = reset_reg;
   assign watchdog_expired_out = expired_reg;

endmodule // supervisor_watchdog_timer

// ===== dv/wdt_props.sv
// assertion checker for the supervisor watchdog timer
`timescale 1ns/100ps
module wdt_props #(
   parameter int TICK_CYCLES   = 2,
   parameter int TIMEOUT_TICKS = 20,
   parameter int HOLD_TICKS    = 5
) (
   input  wire logic sys_clk_in,
   input  wire logic rst_b_in,
   input  wire logic ce_in,
   input  wire logic watchdog_strobe_in,
   input  wire logic strobe_float_in,
   input  wire logic supply_low_in,
   input  wire logic manual_reset_n_in,
   input  wire logic reset_n_out,
   input  wire logic reset_out,
   input  wire logic watchdog_expired_out
);
   localparam int LO = TICK_CYCLES * (TIMEOUT_TICKS - 4);
   localparam int HI = TICK_CYCLES * TIMEOUT_TICKS + 6;
   int q;
   int h;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   // quiet cycles since the last strobe edge, and hold cycles with no cause, counted only while enabled
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q <= 0;
         h <= 0;
      end else if (ce_in) begin
         q <= (reset_out || strobe_float_in || $changed(watchdog_strobe_in)) ? 0 : q + 1;
         h <= (!reset_out || supply_low_in || !manual_reset_n_in) ? 0 : h + 1;
      end
   end
   out_compl_a: assert property (reset_n_out == !reset_out)
      else $error("reset outputs not complementary");
   exp_rst_a: assert property (watchdog_expired_out |-> reset_out && !$past(reset_out))
      else $error("expiry without fresh reset");
   exp_pulse_a: assert property (watchdog_expired_out |=> !watchdog_expired_out)
      else $error("expiry pulse too long");
   cause_rst_a: assert property ((supply_low_in || !manual_reset_n_in) [*5] |-> reset_out)
      else $error("cause did not assert reset");
   float_quiet_a: assert property (strobe_float_in [*6] |-> !watchdog_expired_out)
      else $error("expiry while strobe floating");
   edge_clear_a: assert property ($changed(watchdog_strobe_in) |-> ##4 (!watchdog_expired_out) [*8])
      else $error("expiry right after strobe edge");
   tmo_late_a: assert property (q <= HI)
      else $error("timeout missed");
   tmo_early_a: assert property (watchdog_expired_out |-> $past(q, 4) >= LO)
      else $error("timeout too early");
   hold_short_a: assert property ($fell(reset_out) |-> $past(h) >= TICK_CYCLES * (HOLD_TICKS - 1) - 2)
      else $error("reset hold too short");
   hold_long_a: assert property (h <= TICK_CYCLES * (HOLD_TICKS + 1) + 4)
      else $error("reset hold too long");
endmodule // wdt_props

bind supervisor_watchdog_timer wdt_props #(.TICK_CYCLES(TICK_CYCLES), .TIMEOUT_TICKS(TIMEOUT_TICKS),
   .HOLD_TICKS(HOLD_TICKS)) wdt_props_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
   .watchdog_strobe_in(watchdog_strobe_in), .strobe_float_in(strobe_float_in), .supply_low_in(supply_low_in),
   .manual_reset_n_in(manual_reset_n_in), .reset_n_out(reset_n_out), .reset_out(reset_out),
   .watchdog_expired_out(watchdog_expired_out));

// ===== dv/proc_strobe_model.sv
// processor model that strobes the watchdog input
`timescale 1ns/100ps
module proc_strobe_model (
   input  wire logic       sys_clk_in,
   input  wire logic       drive_in,
   input  wire logic       service_in,
   input  wire logic [7:0] hi_in,
   input  wire logic [7:0] gap_in,
   output logic            strobe_out,
   output logic            float_out
);
   int   n = 0;
   logic drv = 1'b0;
   initial strobe_out = 1'b0;
   initial float_out = 1'b0;
   // high pulse every gap+1 cycles; a stuck routine leaves the line low
   always @(posedge sys_clk_in) begin
      n <= (n >= gap_in) ? 0 : n + 1;
      float_out <= !drive_in;
      if (drive_in)
         drv <= service_in && n < hi_in;
      strobe_out <= drive_in ? (service_in && n < hi_in) : !drv; // released line shows the inverse
   end
endmodule // proc_strobe_model

// ===== dv/test_supervisor_watchdog_timer.sv
// self-checking bench for the supervisor watchdog timer
`timescale 1ns/100ps
module test_supervisor_watchdog_timer;
   localparam int TICK = 2;
   localparam int TMO  = 20;
   localparam int HOLD = 5;
   logic       sys_clk_in        = 1'b0;
   logic       rst_b_in          = 1'b0;
   logic       supply_low_in     = 1'b0;
   logic       manual_reset_n_in = 1'b1;
   logic       drive             = 1'b1;
   logic       ce                = 1'b1;
   logic       service           = 1'b0;
   logic [7:0] hi                = 8'h07;
   logic [7:0] gap               = 8'h24;
   wire        strobe, float_pin, reset_n_out, reset_out, watchdog_expired_out;
   int         n_fail = 0, tests_run = 0, n_exp = 0, e0, c;
   supervisor_watchdog_timer #(.TICK_CYCLES(TICK), .TIMEOUT_TICKS(TMO), .HOLD_TICKS(HOLD))
      supervisor_watchdog_timer_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
      .watchdog_strobe_in(strobe), .strobe_float_in(float_pin), .supply_low_in(supply_low_in),
      .manual_reset_n_in(manual_reset_n_in), .reset_n_out(reset_n_out), .reset_out(reset_out),
      .watchdog_expired_out(watchdog_expired_out));
   proc_strobe_model proc_strobe_model_inst (.sys_clk_in(sys_clk_in), .drive_in(drive), .service_in(service),
      .hi_in(hi), .gap_in(gap), .strobe_out(strobe), .float_out(float_pin));
   initial forever #4 sys_clk_in = ~sys_clk_in;
   // count expiry pulses
   always @(posedge sys_clk_in) if (watchdog_expired_out === 1'b1) n_exp <= n_exp + 1;
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   // cycles until expiry (want_exp) or until reset released
   task automatic wait_for(input bit want_exp, output int n);
      n = 0;
      #1;
      while ((want_exp ? watchdog_expired_out !== 1'b1 : reset_out !== 1'b0) && n < 2000) begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      check("wait in time", n < 2000, 32'h1);
   endtask
   task automatic t_timeout();
      wait_for(0, c);
      wait_for(1, c);
      check("first timeout", c inside {[TICK*TMO-4:TICK*TMO+4]}, 32'h1);
      wait_for(0, c);
      check("hold cycles", c inside {[TICK*HOLD-3:TICK*HOLD+2]}, 32'h1);
      wait_for(1, c);
      check("timeout after hold", c inside {[TICK*TMO-4:TICK*TMO+4]}, 32'h1);
      $display("done: timeout");
   endtask
   task automatic t_cause();
      for (int k = 0; k < 2; k++) begin
         wait_for(0, c);
         repeat (24) @(posedge sys_clk_in);
         supply_low_in <= (k == 0);
         manual_reset_n_in <= (k == 0);
         repeat (10) @(posedge sys_clk_in);
         #1 check("reset during cause", reset_out, 32'h1);
         @(posedge sys_clk_in);
         supply_low_in <= 1'b0;
         manual_reset_n_in <= 1'b1;
         wait_for(0, c);
         wait_for(1, c);
         check("timeout after cause", c inside {[TICK*TMO-4:TICK*TMO+4]}, 32'h1);
      end
      $display("done: causes");
   endtask
   task automatic t_float();
      wait_for(0, c);
      e0 = n_exp;
      @(posedge sys_clk_in);
      drive <= 1'b0;
      repeat (200) @(posedge sys_clk_in);
      #1 check("expiries while floating", n_exp - e0, 32'h0);
      check("reset while floating", reset_out, 32'h0);
      @(posedge sys_clk_in);
      drive <= 1'b1;
      $display("done: floating");
   endtask
   task automatic t_freeze();
      wait_for(1, c);
      wait_for(0, c);
      repeat (20) @(posedge sys_clk_in);
      ce <= 1'b0;
      e0 = n_exp;
      repeat (200) @(posedge sys_clk_in);
      #1 check("expiries while frozen", n_exp - e0, 32'h0);
      check("reset while frozen", reset_out, 32'h0);
      @(posedge sys_clk_in);
      ce <= 1'b1;
      wait_for(1, c);
      check("timeout after freeze", c inside {[TICK*TMO-22:TICK*TMO-18]}, 32'h1);
      $display("done: clock enable");
   endtask
   task automatic t_serviced(input logic [7:0] h, input logic [7:0] g);
      hi <= h;
      gap <= g;
      service <= 1'b1;
      repeat (60) @(posedge sys_clk_in);
      wait_for(0, c);
      e0 = n_exp;
      repeat (300) @(posedge sys_clk_in);
      check("expiries while strobed", n_exp - e0, 32'h0);
      $display("done: strobe %0d of %0d", h, g);
   endtask
   task automatic complete_run();
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      t_timeout();
      t_cause();
      t_float();
      t_freeze();
      t_serviced(8'h07, 8'h24);
      t_serviced(8'h1e, 8'h3c);
      complete_run();
   end
   initial begin
      #60000 n_fail++;
      complete_run();
   end
endmodule // test_supervisor_watchdog_timer
